// ===== hdl/amt_sequencer.sv
// Diagnostic sequencer: three-pass address-independence test
module amt_sequencer (
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               rst_b,
    // Link to memory
    amt_link_if.ctl                 lnk,
    // User control
    input  wire logic               start,
    output logic                    busy,
    output logic                    done,
    output logic                    fail,
    // Failure report
    output logic [7:0]              rpt_port,
    output logic [7:0]              rpt_loc,
    output logic [1:0]              rpt_pass,
    output logic [2:0]              rpt_bank,
    output logic [7:0]              rpt_expected,
    output logic [7:0]              rpt_actual,
    output amt_pkg::amt_fault_t     rpt_fault
);
    import amt_pkg::*;
    `include "amt_defines.svh"

    // -----------------------------------------------------------------
    // Pattern helper
    // -----------------------------------------------------------------
    // Pattern index steps up one per bank and per pass, and down one
    // per location, so neighbouring cells never hold the same value
    function automatic logic [7:0] pat(input logic [1:0] p,
                                       input logic [7:0] loc,
                                       input logic [2:0] b);
        logic [3:0] k;
        k = 4'(({2'b00, p} + 4'(b % 3'd3) + 4'((loc % 8'd3) << 1)) % 4'd3);
        case (k)
            4'd0:    pat = `AMT_PAT_0;
            4'd1:    pat = `AMT_PAT_1;
            default: pat = `AMT_PAT_2;
        endcase
    endfunction : pat

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    // cnt_q counts steps of a write pass or zeroing run; wait_q splits
    // a read into pointer load and registered readback
    amt_state_t st_q;
    logic [11:0] cnt_q;
    logic [1:0]  pass_q;
    logic [7:0]  loc_q;
    logic [2:0]  bank_q;
    logic        wait_q;
    logic [7:0]  wr_loc_q;
    logic [2:0]  wr_bank_q;

    // Expected value rebuilt from pass, location and bank indices
    wire [7:0] exp_w   = pat(pass_q, loc_q, bank_q);
    wire [7:0] act_w   = lnk.rd_data & `AMT_NIBBLE_MASK;
    wire       valid_w = (act_w == `AMT_PAT_0) || (act_w == `AMT_PAT_1) ||
                         (act_w == `AMT_PAT_2);

    // -----------------------------------------------------------------
    // Link drive
    // -----------------------------------------------------------------
    // Steps only while writing or zeroing; all banks selected for writes
    assign lnk.step        = (st_q == AMT_WRITE) || (st_q == AMT_ZERO);
    assign lnk.load_ptr    = (st_q == AMT_READ) && !wait_q;
    assign lnk.ptr_val     = loc_q;
    assign lnk.we_all_ones = (st_q != AMT_WRITE);
    assign lnk.bank_sel_n  = (st_q == AMT_WRITE) ? 8'h00 :
                             ~(8'h01 << bank_q);
    assign lnk.wr_data     = pat(pass_q, wr_loc_q, wr_bank_q);

    // Status straight from state; done and fail hold until a new start
    assign busy = (st_q != AMT_IDLE) && (st_q != AMT_FAIL) &&
                  (st_q != AMT_PASS);
    assign done = (st_q == AMT_PASS) || (st_q == AMT_FAIL);
    assign fail = (st_q == AMT_FAIL);

    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    // A pass is 2056 write steps, one settle cycle, seven zeroing steps,
    // then three cycles for each bank at each location. The first
    // mismatch ends the run, so the report names the earliest one.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_q      <= AMT_IDLE;
            cnt_q     <= 12'd0;
            pass_q    <= 2'd0;
            loc_q     <= 8'h00;
            bank_q    <= 3'd0;
            wait_q    <= 1'b0;
            wr_loc_q  <= 8'h00;
            wr_bank_q <= 3'd0;
            rpt_port     <= 8'h00;
            rpt_loc      <= 8'h00;
            rpt_pass     <= 2'd0;
            rpt_bank     <= 3'd0;
            rpt_expected <= 8'h00;
            rpt_actual   <= 8'h00;
            rpt_fault    <= AMT_FAULT_NONE;
        end else begin
            case (st_q)
                AMT_IDLE, AMT_PASS, AMT_FAIL: begin
                    // Report fields stay put until the next start
                    if (start) begin
                        st_q      <= AMT_WRITE;
                        pass_q    <= 2'd0;
                        cnt_q     <= 12'd0;
                        wr_loc_q  <= 8'h00;
                        wr_bank_q <= 3'd0;
                        rpt_fault <= AMT_FAULT_NONE;
                    end
                end
                AMT_WRITE: begin
                    // Bank index runs fastest, in step with staging phase
                    cnt_q     <= cnt_q + 12'd1;
                    wr_bank_q <= wr_bank_q + 3'd1;
                    if (wr_bank_q == 3'd7) begin
                        wr_loc_q <= wr_loc_q + 8'h01;
                    end
                    if (cnt_q == `AMT_PASS_STEPS - 12'd1) begin
                        st_q <= AMT_WEOFF;
                    end
                end
                AMT_WEOFF: begin
                    // One cycle for the write enables to settle high
                    st_q  <= AMT_ZERO;
                    cnt_q <= 12'd0;
                end
                AMT_ZERO: begin
                    // Seven steps walk the even phases that clear pointers
                    cnt_q <= cnt_q + 12'd1;
                    if (cnt_q == 12'(`AMT_ZERO_STEPS) - 12'd1) begin
                        st_q   <= AMT_READ;
                        loc_q  <= 8'h00;
                        bank_q <= 3'd0;
                        wait_q <= 1'b0;
                    end
                end
                AMT_READ: begin
                    // Two cycles: load pointer, then registered readback
                    wait_q <= ~wait_q;
                    if (wait_q) begin
                        st_q <= AMT_CHECK;
                    end
                end
                AMT_CHECK: begin
                    // Banks advance first, then locations, then passes
                    wait_q <= 1'b0;
                    if (act_w != exp_w) begin
                        // Latch the whole report at the first failure
                        st_q         <= AMT_FAIL;
                        rpt_port     <= `AMT_READ_PORT;
                        rpt_loc      <= loc_q;
                        rpt_pass     <= pass_q;
                        rpt_bank     <= bank_q;
                        rpt_expected <= exp_w;
                        rpt_actual   <= act_w;
                        // Location 0 faults stay unclassified
                        if (loc_q == 8'h00) begin
                            rpt_fault <= AMT_FAULT_NONE;
                        end else if (valid_w) begin
                            rpt_fault <= AMT_FAULT_PTR;
                        end else begin
                            rpt_fault <= AMT_FAULT_RAM;
                        end
                    end else if (bank_q != 3'd7) begin
                        bank_q <= bank_q + 3'd1;
                        st_q   <= AMT_READ;
                    end else if (loc_q != 8'hFF) begin
                        bank_q <= 3'd0;
                        loc_q  <= loc_q + 8'h01;
                        st_q   <= AMT_READ;
                    end else if (pass_q != 2'd2) begin
                        pass_q    <= pass_q + 2'd1;
                        cnt_q     <= 12'd0;
                        wr_loc_q  <= 8'h00;
                        wr_bank_q <= 3'd0;
                        bank_q    <= 3'd0;
                        st_q      <= AMT_WRITE;
                    end else begin
                        st_q <= AMT_PASS;
                    end
                end
                default: st_q <= AMT_IDLE;
            endcase
        end
    end
endmodule : amt_sequencer

// ===== hdl/amt_defines.svh
// Constants for the acquisition memory pattern test
`ifndef AMT_DEFINES_SVH
`define AMT_DEFINES_SVH
`define AMT_PAT_0       8'h0A
`define AMT_PAT_1       8'h01
`define AMT_PAT_2       8'h0C
`define AMT_NIBBLE_MASK 8'h0F
`define AMT_READ_PORT   8'h04
`define AMT_SEL_PORT    8'h07
`define AMT_PASS_STEPS  12'd2056
`define AMT_ZERO_STEPS  3'd7
`define AMT_STAGE_STEPS 3'd7
`define AMT_WE_OFF      8'hFF
`define AMT_LOCS        9'd256
`define AMT_PTR_RESET   8'hFF
`endif

// ===== hdl/amt_pkg.sv
// Types for the acquisition memory pattern test
package amt_pkg;
    typedef enum logic [2:0] {
        AMT_IDLE  = 3'b000,
        AMT_WRITE = 3'b001,
        AMT_WEOFF = 3'b010,
        AMT_ZERO  = 3'b011,
        AMT_READ  = 3'b100,
        AMT_CHECK = 3'b101,
        AMT_FAIL  = 3'b110,
        AMT_PASS  = 3'b111
    } amt_state_t;
    typedef enum logic [1:0] {
        AMT_FAULT_NONE = 2'b00,
        AMT_FAULT_PTR  = 2'b01,
        AMT_FAULT_RAM  = 2'b10
    } amt_fault_t;
endpackage : amt_pkg

// ===== hdl/amt_link_if.sv
// Interface joining the memory under test and the diagnostic sequencer
interface amt_link_if;
    logic       step;
    logic       load_ptr;
    logic [7:0] ptr_val;
    logic       we_all_ones;
    logic [7:0] bank_sel_n;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic       phase_clock_zero;
    logic       phase_clock_two;
    logic       phase_clock_four;
    logic       phase_clock_six;
    modport mem (input step, load_ptr, ptr_val, we_all_ones, bank_sel_n,
                 wr_data, output rd_data, phase_clock_zero,
                 phase_clock_two, phase_clock_four, phase_clock_six);
    modport ctl (output step, load_ptr, ptr_val, we_all_ones, bank_sel_n,
                 wr_data, input rd_data, phase_clock_zero,
                 phase_clock_two, phase_clock_four, phase_clock_six);
endinterface : amt_link_if

// ===== hdl/amt_memory.sv
// Eight-bank acquisition memory with staged latches and clock array
module amt_memory #(
    parameter int  DEPTH     = 256,
    parameter bit  IS_MASTER = 1'b1
) (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_b,
    // Link to the sequencer
    amt_link_if.mem         lnk,
    // Slow-card clock capture
    input  wire logic [7:0] slow_clk_data,
    output logic [7:0]      clk_array_rd
);
    import amt_pkg::*;
    `include "amt_defines.svh"

    // -----------------------------------------------------------------
    // Storage
    // -----------------------------------------------------------------
    logic [3:0] bank_mem [8][DEPTH];
    logic [3:0] carr_lo  [DEPTH];
    logic [3:0] carr_hi  [DEPTH];
    logic [7:0] location_pointer_q;
    logic [7:0] staged_ptr_q;
    logic [3:0] stage_buf_q [8];
    logic [3:0] stage_nib [8];
    logic [2:0] phase_q;
    logic [7:0] rd_data_q;
    logic [7:0] carr_rd_q;
    logic [3:0] bank_nib [8];

    // Phase strobes; even phases clear pointers while zeroing
    assign lnk.phase_clock_zero = lnk.step && (phase_q == 3'd0);
    assign lnk.phase_clock_two  = lnk.step && (phase_q == 3'd2);
    assign lnk.phase_clock_four = lnk.step && (phase_q == 3'd4);
    assign lnk.phase_clock_six  = lnk.step && (phase_q == 3'd6);
    wire stage_tick = lnk.step && (phase_q == `AMT_STAGE_STEPS);
    wire we_n       = lnk.we_all_ones;
    // Writes need enables low; zeroing runs only with them all high
    wire step_wr    = lnk.step && !we_n;
    wire write_tick = stage_tick && !we_n;
    wire zero_tick  = lnk.step && we_n && !phase_q[0];
    assign lnk.rd_data  = rd_data_q;
    assign clk_array_rd = carr_rd_q;

    // Pointers, phase and staged data
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            // Pointer sits one behind the staged pointer, so the
            // first staged write lands at location 00
            location_pointer_q <= `AMT_PTR_RESET;
            staged_ptr_q       <= 8'h00;
            phase_q            <= 3'd0;
        end else if (lnk.load_ptr) begin
            location_pointer_q <= lnk.ptr_val;
            staged_ptr_q       <= lnk.ptr_val + 8'h01;
            phase_q            <= 3'd0;
        end else if (lnk.step) begin
            phase_q <= phase_q + 3'd1;
            if (zero_tick) begin
                location_pointer_q <= 8'h00;
                staged_ptr_q       <= 8'h00;
            end else if (write_tick) begin
                location_pointer_q <= staged_ptr_q;
                staged_ptr_q       <= staged_ptr_q + 8'h01;
            end
        end
    end

    // Each step stages one bank's nibble; all eight land at phase 7
    always_ff @(posedge mclk) begin
        if (step_wr) begin
            stage_buf_q[phase_q] <= lnk.wr_data[3:0];
        end
        for (int b = 0; b < 8; b++) begin
            if (write_tick && !lnk.bank_sel_n[b]) begin
                bank_mem[b][staged_ptr_q] <= stage_nib[b];
            end
        end
        if (IS_MASTER && write_tick) begin
            // Both arrays capture at every staged write, at the staged pointer: low array bits 3:0, high array bits 7:4
            carr_lo[staged_ptr_q] <= slow_clk_data[3:0];
            carr_hi[staged_ptr_q] <= slow_clk_data[7:4];
        end
    end

    // Readback: one selected bank, upper nibble reads zero
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            bank_nib[b] = bank_mem[b][location_pointer_q];
            // Bank 7 arrives on the write step itself, so it bypasses
            stage_nib[b] = (b == 7) ? lnk.wr_data[3:0] : stage_buf_q[b];
        end
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_q <= 8'h00;
            carr_rd_q <= 8'h00;
        end else begin
            rd_data_q <= 8'h00;
            for (int b = 0; b < 8; b++) begin
                if (!lnk.bank_sel_n[b] && we_n) begin
                    rd_data_q <= {4'h0, bank_nib[b]};
                end
            end
            carr_rd_q <= IS_MASTER ? {carr_hi[location_pointer_q],
                                      carr_lo[location_pointer_q]} : 8'h00;
        end
    end
endmodule : amt_memory

// ===== dv/amt_link_properties.sv
// Checker watching the link between memory and sequencer
module amt_link_properties (
    // Clock and reset
    input logic       mclk,
    input logic       rst_b,
    // Link signals
    input logic       step,
    input logic       load_ptr,
    input logic       we_all_ones,
    input logic [7:0] bank_sel_n,
    input logic [7:0] rd_data,
    input logic       phase_clock_zero,
    input logic       phase_clock_six
);
    // ----------------------------------------
    // Step counters
    // ----------------------------------------
    logic [11:0] wcnt_q;
    logic [2:0]  zcnt_q;
    // Write steps reset once writes stop; zeroing steps once they resume
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wcnt_q <= 12'h000;
            zcnt_q <= 3'h0;
        end else begin
            wcnt_q <= we_all_ones ? 12'h000 : wcnt_q + 12'(step);
            zcnt_q <= !we_all_ones ? 3'h0 : zcnt_q + 3'(step);
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    property p_upper_zero; rd_data[7:4] == 4'h0; endproperty
    property p_one_bank; load_ptr |-> $countones(~bank_sel_n) == 1;
    endproperty
    property p_read_we; load_ptr |-> we_all_ones; endproperty
    property p_write_all; step && !we_all_ones |-> bank_sel_n == 8'h00;
    endproperty
    property p_pass_len; $rose(we_all_ones) |-> wcnt_q == 12'd2056;
    endproperty
    property p_zero_len; load_ptr |-> zcnt_q == 3'd7; endproperty
    property p_zero_ph0; $rose(we_all_ones) |-> ##[1:12] phase_clock_zero;
    endproperty
    property p_zero_ph6; $rose(we_all_ones) |-> ##[1:12] phase_clock_six;
    endproperty
    property p_pattern;
        load_ptr |-> ##2 rd_data inside {8'h0A, 8'h01, 8'h0C};
    endproperty
    property p_spacing; load_ptr |=> !load_ptr [*2]; endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("readback upper nibble not zero");
    a_one_bank: assert property (p_one_bank)
        else $error("read without exactly one bank selected");
    a_read_we: assert property (p_read_we)
        else $error("read while writes enabled");
    a_write_all: assert property (p_write_all)
        else $error("write step without all banks selected");
    a_pass_len: assert property (p_pass_len)
        else $error("write pass step count wrong");
    a_zero_len: assert property (p_zero_len)
        else $error("zeroing step count wrong");
    a_zero_ph0: assert property (p_zero_ph0)
        else $error("phase zero strobe missing");
    a_zero_ph6: assert property (p_zero_ph6)
        else $error("phase six strobe missing");
    a_pattern: assert property (p_pattern)
        else $error("readback not a test pattern");
    a_spacing: assert property (p_spacing)
        else $error("pointer loads too close");
    c_read: cover property (load_ptr && bank_sel_n == 8'h7F);
    c_pass: cover property ($rose(we_all_ones));
    c_ph6: cover property (phase_clock_six);
endmodule : amt_link_properties

// ===== dv/acq_memory_pattern_test_tb.sv
// Testbench: healthy pair, plus a sequencer facing a faulty stand-in
module acq_memory_pattern_test_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import amt_pkg::*;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    localparam logic [7:0] VALS [3] = '{8'h07, 8'h0A, 8'h07};
    localparam logic [7:0] FROMS [3] = '{8'h01, 8'h01, 8'h00};
    localparam logic [7:0] EXPS [3] = '{8'h0C, 8'h0C, 8'h0A};
    localparam logic [7:0] FLTS [3] = '{8'h02, 8'h01, 8'h00};
    logic       mclk, rst_b, start, start_f, busy, done, fail;
    logic       busy_f, done_f, fail_f;
    logic [7:0] port_f, loc_f, exp_f, act_f, bad_val, bad_from, loc_q;
    logic [7:0] carr_rd;
    logic [1:0] pass_f;
    logic [2:0] bank_f;
    amt_fault_t fault_f;
    int         err_count, n_checks, i;
    longint     t0;
    amt_link_if lnk ();
    amt_link_if lnk_f ();
    amt_memory #(.DEPTH(256), .IS_MASTER(1'b1)) u_amt_memory (
        .mclk(mclk), .rst_b(rst_b), .lnk(lnk),
        .slow_clk_data(8'hA5), .clk_array_rd(carr_rd));
    amt_sequencer u_amt_sequencer (.mclk(mclk), .rst_b(rst_b), .lnk(lnk),
        .start(start), .busy(busy), .done(done), .fail(fail),
        .rpt_port(), .rpt_loc(), .rpt_pass(), .rpt_bank(),
        .rpt_expected(), .rpt_actual(), .rpt_fault());
    amt_sequencer u_amt_sequencer_f (.mclk(mclk), .rst_b(rst_b),
        .lnk(lnk_f), .start(start_f), .busy(busy_f), .done(done_f),
        .fail(fail_f), .rpt_port(port_f), .rpt_loc(loc_f),
        .rpt_pass(pass_f), .rpt_bank(bank_f), .rpt_expected(exp_f),
        .rpt_actual(act_f), .rpt_fault(fault_f));
    amt_link_properties u_amt_link_properties (.mclk(mclk), .rst_b(rst_b),
        .step(lnk.step), .load_ptr(lnk.load_ptr),
        .we_all_ones(lnk.we_all_ones), .bank_sel_n(lnk.bank_sel_n),
        .rd_data(lnk.rd_data), .phase_clock_zero(lnk.phase_clock_zero),
        .phase_clock_six(lnk.phase_clock_six));
    // Good pattern of the selected bank at location zero, first pass
    function automatic logic [7:0] good_pat(input logic [7:0] sel);
        logic [7:0] pats [3];
        int         b;
        pats = '{8'h0A, 8'h01, 8'h0C};
        b = 0;
        for (int k = 0; k < 8; k++) if (!sel[k]) b = k;
        return pats[b % 3];
    endfunction : good_pat
    // Faulty stand-in: phase strobes idle, bad data from bad_from upward
    assign {lnk_f.phase_clock_zero, lnk_f.phase_clock_two,
            lnk_f.phase_clock_four, lnk_f.phase_clock_six} = 4'h0;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            loc_q <= 8'h00;
            lnk_f.rd_data <= 8'h00;
        end else begin
            if (lnk_f.load_ptr) loc_q <= lnk_f.ptr_val;
            lnk_f.rd_data <= (loc_q < bad_from) ?
                good_pat(lnk_f.bank_sel_n) : bad_val;
        end
    end
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop
    // One-cycle start; returns once its edge has landed
    task automatic pulse(input bit flt);
        @(posedge mclk);
        if (flt) start_f <= 1'b1;
        else start <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
        start_f <= 1'b0;
        @(negedge mclk);
    endtask : pulse
    // Bounded wait for the end of a run
    task automatic wait_end(input bit flt, input int lim);
        i = 0;
        while ((flt ? done_f | fail_f : done | fail) !== 1'b1) begin
            @(negedge mclk);
            i++;
            if (i > lim) begin
                err_count++;
                $display("BAD %0t: run did not finish", $time);
                report_and_stop();
            end
        end
    endtask : wait_end
    initial begin
        err_count = 0;
        n_checks = 0;
        start = 1'b0;
        start_f = 1'b0;
        rst_b = 1'b0;
        bad_val = 8'h07;
        bad_from = 8'h01;
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        // Healthy run; a start while busy must be ignored
        pulse(1'b0);
        t0 = $time;
        repeat (100) @(negedge mclk);
        check({7'h0, busy}, 8'h01);
        pulse(1'b0);
        wait_end(1'b0, 30000);
        check({7'h0, fail}, 8'h00);
        check({7'h0, done}, 8'h01);
        check(carr_rd, 8'hA5);
        check(8'(($time - t0) / 20 >= 24620), 8'h01);
        // Bank fault, pointer fault, then a fault at location zero
        for (int k = 0; k < 3; k++) begin
            bad_val <= VALS[k];
            bad_from <= FROMS[k];
            pulse(1'b1);
            wait_end(1'b1, 3000);
            check({7'h0, fail_f}, 8'h01);
            check(port_f, 8'h04);
            check(loc_f, FROMS[k]);
            check({6'h0, pass_f}, 8'h00);
            check({5'h0, bank_f}, 8'h00);
            check(exp_f, EXPS[k]);
            check(act_f, VALS[k]);
            check(8'(fault_f), FLTS[k]);
        end
        report_and_stop();
    end
endmodule : acq_memory_pattern_test_tb
